// file: hw/ifc_config_decoder.sv
// Configuration register bank and I/O decoder of a multi-function ISA peripheral.
// Assumes ISA strobes and address are already synchronous to sys_clk_i.
// Behaviour
// RULE1 - Index and data ports sit at 398h/399h, or 26Eh/26Fh with strap high.
// RULE2 - Host loads index, then two consecutive data writes; second write updates register.
// RULE3 - Index read returns last index; data read returns selected register directly.
// RULE4 - Reset loads first three registers from one of 32 strap-selected sets.
// RULE5 - Lock bit stops further configuration writes until hardware reset.
// RULE6 - Enable bit 0 decodes the parallel port at the address field range.
// RULE7 - Enable bits 1, 2 gate each UART access and clock; contents kept.
// RULE8 - A disabled UART still drives its pending interrupt request.
// RULE9 - Host should clear UART interrupt output enable before disabling that UART.
// RULE10 - Enable bit 3 gates floppy access and clock; one decodes floppy range.
// RULE11 - Enable bit 4 selects direct two-drive pins or encoded four-drive pins.
// RULE12 - Encoded: select pins carry drive number; motor zero low when its motor bit set.
// RULE13 - Encoded: motor one pulses with write strobe to 3F2h or 372h.
// RULE14 - External decoder enables nothing for undefined pin combinations.
// RULE15 - Enable bit 5 picks floppy range 3F0-7h or 370-7h.
// RULE16 - Enable bit 6 zero blocks IDE, idles selects and buffers, floats data bit 7.
// RULE17 - Enable bit 7 picks IDE ranges 1F0-7h/3F6-7h or 170-7h/376-7h.
// RULE18 - Address bits 1:0 pick parallel range and interrupt; code 11 floats interrupt.
// RULE19 - Power test bit 3 moves 378-37F parallel interrupt to IRQ7.
// RULE20 - Address bits 3:2 assign first UART a serial port slot.
// RULE21 - Address bits 5:4 assign second UART a slot with the same codes.
// RULE22 - Address bits 7:6 set port 3 and port 4 ranges.
// RULE23 - Every match is qualified with address-enable inactive.
// RULE24 - Reserved parallel code decodes no parallel range.
`timescale 1ns/10ps
`default_nettype none
module ifc_config_decoder (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic config_base_strap_i,
    input wire logic [4:0] default_config_straps_i,
    input wire logic [9:0] isa_addr_i,
    input wire logic aen_i,
    input wire logic iow_n_i,
    input wire logic ior_n_i,
    input wire logic [7:0] isa_data_i,
    input wire logic [7:0] fdc_dor_i,
    input wire logic uart1_irq_i,
    input wire logic uart2_irq_i,
    input wire logic par_irq_i,
    output logic [7:0] isa_data_o,
    output logic isa_data_oe_o,
    output logic fdc_cs_o,
    output logic uart1_cs_o,
    output logic uart2_cs_o,
    output logic par_cs_o,
    output logic fdc_clk_en_o,
    output logic uart1_clk_en_o,
    output logic uart2_clk_en_o,
    output logic uart1_irq_o,
    output logic uart2_irq_o,
    output logic par_irq5_o,
    output logic par_irq5_oe_o,
    output logic par_irq7_o,
    output logic par_irq7_oe_o,
    output logic ide_chip_select_zero_n_o,
    output logic ide_chip_select_one_n_o,
    output logic ide_low_buffer_enable_n_o,
    output logic ide_high_buffer_enable_n_o,
    output logic ide_data_bit_seven_o,
    output logic ide_data_bit_seven_oe_o,
    output logic drive_select_pin_zero_o,
    output logic drive_select_pin_one_o,
    output logic motor_pin_zero_o,
    output logic motor_pin_one_o
);
    logic [7:0] fen_q;
    logic [7:0] far_q;
    logic [7:0] ptr_q;
    logic [7:0] index_q;
    ifc_pkg::ifc_wphase_e phase_q;
    logic iow_n_q;
    logic cfg_idx_hit;
    logic cfg_data_hit;
    logic wr_stb;
    logic wr_idx;
    logic wr_dat;
    logic wr_other;
    logic commit;
    logic [7:0] rd_val;
    logic [9:0] fdc_lo;
    logic [9:0] fdc_dor;
    logic [9:0] ide_lo;
    logic [9:0] ide_alt;
    logic [9:0] u1_lo;
    logic [9:0] u2_lo;
    logic [9:0] par_lo;
    logic [9:0] par_hi;
    logic par_valid;
    logic fdc_hit;
    logic u1_hit;
    logic u2_hit;
    logic par_hit;
    logic ide0_hit;
    logic ide1_hit;
    logic dor_hit;
    logic io_strobe;
    logic [1:0] drv_sel;

    // Slot base for a serial port code; ports 3 and 4 follow the upper field.
    function automatic logic [9:0] com_lo(input logic [1:0] slot, input logic [1:0] set);
        logic [9:0] base;
        base = ifc_pkg::COM1_LO;
        case (slot)
            2'h0: base = ifc_pkg::COM1_LO;
            2'h1: base = ifc_pkg::COM2_LO;
            2'h2: base = ifc_pkg::COM3_LO[set]; // RULE22
            default: base = ifc_pkg::COM4_LO[set]; // RULE22
        endcase
        return base;
    endfunction : com_lo

    // Configuration ports move with the base strap and ignore DMA cycles.
    always_comb
    begin
        if (config_base_strap_i) // RULE1
        begin
            cfg_idx_hit = !aen_i && (isa_addr_i == ifc_pkg::IDX_PORT_HI); // RULE23
            cfg_data_hit = !aen_i && (isa_addr_i == ifc_pkg::DATA_PORT_HI);
        end
        else
        begin
            cfg_idx_hit = !aen_i && (isa_addr_i == ifc_pkg::IDX_PORT_LO); // RULE1
            cfg_data_hit = !aen_i && (isa_addr_i == ifc_pkg::DATA_PORT_LO);
        end
    end

    // A write is taken once, on the falling edge of the write strobe.
    assign wr_stb = iow_n_q && !iow_n_i && !aen_i;
    assign wr_idx = wr_stb && cfg_idx_hit;
    assign wr_dat = wr_stb && cfg_data_hit;
    assign wr_other = wr_stb && !cfg_idx_hit && !cfg_data_hit;
    assign commit = wr_dat && (phase_q == ifc_pkg::WP_ARMED) && !ptr_q[ifc_pkg::PTR_LOCK]; // RULE2 RULE5
    assign io_strobe = !iow_n_i || !ior_n_i;
    assign drv_sel = fdc_dor_i[1:0];

    // Strobe history for edge detection.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            iow_n_q <= 1'b1;
        else
            iow_n_q <= iow_n_i;
    end

    // Index register and the two-write phase; any other write breaks the pair.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            index_q <= 8'h00;
            phase_q <= ifc_pkg::WP_IDLE;
        end
        else if (wr_idx)
        begin
            index_q <= isa_data_i;
            phase_q <= ifc_pkg::WP_IDLE;
        end
        else if (wr_dat)
        begin
            case (phase_q)
                ifc_pkg::WP_IDLE: phase_q <= ifc_pkg::WP_ARMED; // RULE2
                ifc_pkg::WP_ARMED: phase_q <= ifc_pkg::WP_IDLE;
                default: phase_q <= ifc_pkg::WP_IDLE;
            endcase
        end
        else if (wr_other)
            phase_q <= ifc_pkg::WP_IDLE;
    end

    // Configuration registers; the reset set comes from the straps at reset.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            fen_q <= ifc_pkg::FEN_DEF[default_config_straps_i]; // RULE4
            far_q <= ifc_pkg::FAR_DEF[default_config_straps_i]; // RULE4
            ptr_q <= (default_config_straps_i == ifc_pkg::STRAP_NONE) ?
                     ifc_pkg::PTR_DEF_NONE : ifc_pkg::PTR_DEF; // RULE4 RULE5
        end
        else if (commit)
        begin
            if (index_q == ifc_pkg::IDX_FEN)
                fen_q <= isa_data_i;
            else if (index_q == ifc_pkg::IDX_FAR)
                far_q <= isa_data_i;
            else if (index_q == ifc_pkg::IDX_PTR)
                ptr_q <= isa_data_i; // RULE5
        end
    end

    // Read mux for the data port; unimplemented indices read zero.
    always_comb
    begin
        if (index_q == ifc_pkg::IDX_FEN)
            rd_val = fen_q;
        else if (index_q == ifc_pkg::IDX_FAR)
            rd_val = far_q;
        else if (index_q == ifc_pkg::IDX_PTR)
            rd_val = ptr_q;
        else
            rd_val = 8'h00;
    end

    // Read data is driven while the read strobe stays low on a config port.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            isa_data_o <= 8'h00;
            isa_data_oe_o <= 1'b0;
        end
        else
        begin
            isa_data_oe_o <= !ior_n_i && (cfg_idx_hit || cfg_data_hit);
            if (!ior_n_i && cfg_idx_hit)
                isa_data_o <= index_q; // RULE3
            else if (!ior_n_i && cfg_data_hit)
                isa_data_o <= rd_val; // RULE3
            else
                isa_data_o <= 8'h00;
        end
    end

    // Range selection from the enable and address registers.
    always_comb
    begin
        fdc_lo = fen_q[ifc_pkg::FEN_FDC_SEC] ? ifc_pkg::FDC_SEC_LO : ifc_pkg::FDC_PRI_LO; // RULE15
        fdc_dor = fen_q[ifc_pkg::FEN_FDC_SEC] ? ifc_pkg::FDC_DOR_SEC : ifc_pkg::FDC_DOR_PRI; // RULE13
        ide_lo = fen_q[ifc_pkg::FEN_IDE_SEC] ? ifc_pkg::IDE_SEC_LO : ifc_pkg::IDE_PRI_LO; // RULE17
        ide_alt = fen_q[ifc_pkg::FEN_IDE_SEC] ? ifc_pkg::IDE_SEC_ALT : ifc_pkg::IDE_PRI_ALT; // RULE17
        u1_lo = com_lo(far_q[3:2], far_q[7:6]); // RULE20
        u2_lo = com_lo(far_q[5:4], far_q[7:6]); // RULE21
        par_valid = 1'b1;
        par_lo = ifc_pkg::PAR_A_LO;
        par_hi = ifc_pkg::PAR_A_LO + ifc_pkg::SPAN8;
        if (far_q[1:0] == ifc_pkg::PAR_CODE_B) // RULE18
        begin
            par_lo = ifc_pkg::PAR_B_LO;
            par_hi = ifc_pkg::PAR_B_HI;
        end
        else if (far_q[1:0] == ifc_pkg::PAR_CODE_C)
        begin
            par_lo = ifc_pkg::PAR_C_LO;
            par_hi = ifc_pkg::PAR_C_LO + ifc_pkg::SPAN8;
        end
        else if (far_q[1:0] != ifc_pkg::PAR_CODE_A)
            par_valid = 1'b0; // RULE24
    end

    // Every comparator is enabled only outside DMA cycles.
    ifc_range_match u_fdc (
        .addr_i(isa_addr_i),
        .lo_i(fdc_lo),
        .hi_i(fdc_lo + ifc_pkg::SPAN8),
        .en_i(!aen_i && fen_q[ifc_pkg::FEN_FDC]), // RULE10 RULE23
        .hit_o(fdc_hit)
    );
    ifc_range_match u_uart1 (
        .addr_i(isa_addr_i),
        .lo_i(u1_lo),
        .hi_i(u1_lo + ifc_pkg::SPAN8),
        .en_i(!aen_i && fen_q[ifc_pkg::FEN_UART1]), // RULE7
        .hit_o(u1_hit)
    );
    ifc_range_match u_uart2 (
        .addr_i(isa_addr_i),
        .lo_i(u2_lo),
        .hi_i(u2_lo + ifc_pkg::SPAN8),
        .en_i(!aen_i && fen_q[ifc_pkg::FEN_UART2]), // RULE7
        .hit_o(u2_hit)
    );
    ifc_range_match u_par (
        .addr_i(isa_addr_i),
        .lo_i(par_lo),
        .hi_i(par_hi),
        .en_i(!aen_i && fen_q[ifc_pkg::FEN_PAR] && par_valid), // RULE6 RULE24
        .hit_o(par_hit)
    );
    ifc_range_match u_ide0 (
        .addr_i(isa_addr_i),
        .lo_i(ide_lo),
        .hi_i(ide_lo + ifc_pkg::SPAN8),
        .en_i(!aen_i && fen_q[ifc_pkg::FEN_IDE]), // RULE16
        .hit_o(ide0_hit)
    );
    ifc_range_match u_ide1 (
        .addr_i(isa_addr_i),
        .lo_i(ide_alt),
        .hi_i(ide_alt + ifc_pkg::SPAN2),
        .en_i(!aen_i && fen_q[ifc_pkg::FEN_IDE]), // RULE16
        .hit_o(ide1_hit)
    );
    // The drive latch strobe decodes regardless of the floppy enable.
    ifc_range_match u_dor (
        .addr_i(isa_addr_i),
        .lo_i(fdc_dor),
        .hi_i(fdc_dor),
        .en_i(!aen_i),
        .hit_o(dor_hit)
    );

    // Chip selects and clock gates; a blocked function keeps its own state.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            fdc_cs_o <= 1'b0;
            uart1_cs_o <= 1'b0;
            uart2_cs_o <= 1'b0;
            par_cs_o <= 1'b0;
            fdc_clk_en_o <= 1'b0;
            uart1_clk_en_o <= 1'b0;
            uart2_clk_en_o <= 1'b0;
        end
        else
        begin
            fdc_cs_o <= fdc_hit; // RULE10
            uart1_cs_o <= u1_hit; // RULE7
            uart2_cs_o <= u2_hit; // RULE7
            par_cs_o <= par_hit; // RULE6
            fdc_clk_en_o <= fen_q[ifc_pkg::FEN_FDC]; // RULE10
            uart1_clk_en_o <= fen_q[ifc_pkg::FEN_UART1]; // RULE7
            uart2_clk_en_o <= fen_q[ifc_pkg::FEN_UART2]; // RULE7
        end
    end

    // UART requests pass through even when the UART is disabled, so software must mask them first.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            uart1_irq_o <= 1'b0;
            uart2_irq_o <= 1'b0;
        end
        else
        begin
            uart1_irq_o <= uart1_irq_i; // RULE8 RULE9
            uart2_irq_o <= uart2_irq_i; // RULE8 RULE9
        end
    end

    // Parallel interrupt steering; the reserved code leaves both lines undriven.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            par_irq5_oe_o <= 1'b0;
            par_irq7_oe_o <= 1'b0;
            par_irq5_o <= 1'b0;
            par_irq7_o <= 1'b0;
        end
        else
        begin
            par_irq5_o <= par_irq_i;
            par_irq7_o <= par_irq_i;
            par_irq5_oe_o <= 1'b0;
            par_irq7_oe_o <= 1'b0;
            if (!fen_q[ifc_pkg::FEN_PAR])
                par_irq5_oe_o <= 1'b0;
            else if (far_q[1:0] == ifc_pkg::PAR_CODE_A)
            begin
                par_irq7_oe_o <= ptr_q[ifc_pkg::PTR_LPT_IRQ7]; // RULE19
                par_irq5_oe_o <= !ptr_q[ifc_pkg::PTR_LPT_IRQ7]; // RULE19
            end
            else if (far_q[1:0] == ifc_pkg::PAR_CODE_B)
                par_irq7_oe_o <= 1'b1; // RULE18
            else if (far_q[1:0] == ifc_pkg::PAR_CODE_C)
                par_irq5_oe_o <= 1'b1; // RULE18
        end
    end

    // IDE selects are active low and idle high while the interface is off.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            ide_chip_select_zero_n_o <= 1'b1;
            ide_chip_select_one_n_o <= 1'b1;
            ide_low_buffer_enable_n_o <= 1'b1;
            ide_high_buffer_enable_n_o <= 1'b1;
            ide_data_bit_seven_o <= 1'b0;
            ide_data_bit_seven_oe_o <= 1'b0;
        end
        else
        begin
            ide_chip_select_zero_n_o <= !ide0_hit; // RULE16 RULE17
            ide_chip_select_one_n_o <= !ide1_hit; // RULE16 RULE17
            ide_low_buffer_enable_n_o <= !((ide0_hit || ide1_hit) && io_strobe); // RULE16
            ide_high_buffer_enable_n_o <= !(ide0_hit && (isa_addr_i == ide_lo) && io_strobe); // RULE16
            ide_data_bit_seven_o <= isa_data_i[7];
            ide_data_bit_seven_oe_o <= ide0_hit && !iow_n_i; // RULE16
        end
    end

    // Drive pins: direct active-low pins, or a drive number for an external decoder.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            drive_select_pin_zero_o <= 1'b1;
            drive_select_pin_one_o <= 1'b1;
            motor_pin_zero_o <= 1'b1;
            motor_pin_one_o <= 1'b1;
        end
        else if (fen_q[ifc_pkg::FEN_ENC]) // RULE11
        begin
            drive_select_pin_zero_o <= drv_sel[0]; // RULE12
            drive_select_pin_one_o <= drv_sel[1]; // RULE12
            motor_pin_zero_o <= !fdc_dor_i[{1'b1, drv_sel}]; // RULE12 RULE14
            motor_pin_one_o <= dor_hit && !iow_n_i; // RULE13
        end
        else
        begin
            drive_select_pin_zero_o <= !(drv_sel == 2'h0); // RULE11
            drive_select_pin_one_o <= !(drv_sel == 2'h1); // RULE11
            motor_pin_zero_o <= !fdc_dor_i[4];
            motor_pin_one_o <= !fdc_dor_i[5];
        end
    end

    a_lock_freezes: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE5
        ptr_q[ifc_pkg::PTR_LOCK] |=> $stable(fen_q) && $stable(far_q) && $stable(ptr_q))
        else $error("Configuration changed while locked.");
    a_single_write_holds: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE2
        (wr_dat && phase_q == ifc_pkg::WP_IDLE) |=> $stable(fen_q) && $stable(far_q))
        else $error("First data write updated a register.");
    a_index_readback: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE3
        (!ior_n_i && cfg_idx_hit) |=> isa_data_oe_o && (isa_data_o == $past(index_q)))
        else $error("Index read returned wrong value.");
    a_uart_gate: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE7
        !fen_q[ifc_pkg::FEN_UART1] |=> !uart1_cs_o && !uart1_clk_en_o)
        else $error("Disabled UART still selected or clocked.");
    a_ide_idle: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE16
        !fen_q[ifc_pkg::FEN_IDE] |=> ide_chip_select_zero_n_o && ide_chip_select_one_n_o
        && ide_low_buffer_enable_n_o && ide_high_buffer_enable_n_o && !ide_data_bit_seven_oe_o)
        else $error("Disabled IDE interface is active.");
    a_enc_drive: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE12
        fen_q[ifc_pkg::FEN_ENC] |=> {drive_select_pin_one_o, drive_select_pin_zero_o} == $past(fdc_dor_i[1:0]))
        else $error("Encoded drive number wrong.");
    a_motor_pulse: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE13
        (fen_q[ifc_pkg::FEN_ENC] && !aen_i && !iow_n_i && isa_addr_i == fdc_dor) |=> motor_pin_one_o)
        else $error("Motor one pin missed the write pulse.");
    a_par_reserved: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE24
        (far_q[1:0] == 2'h3) |=> !par_cs_o && !par_irq5_oe_o && !par_irq7_oe_o)
        else $error("Reserved parallel code decoded.");
    a_dma_ignored: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE23
        aen_i |=> !fdc_cs_o && !uart1_cs_o && !uart2_cs_o && !par_cs_o)
        else $error("Peripheral decoded during DMA.");
    c_commit: cover property (@(posedge sys_clk_i) disable iff (srst_i) commit);
    c_lock_set: cover property (@(posedge sys_clk_i) disable iff (srst_i) $rose(ptr_q[ifc_pkg::PTR_LOCK]));
    c_enc_pulse: cover property (@(posedge sys_clk_i) disable iff (srst_i)
        fen_q[ifc_pkg::FEN_ENC] && motor_pin_one_o);
endmodule : ifc_config_decoder
`default_nettype wire

// file: hw/ifc_pkg.sv
// Constants for the ISA function configuration decoder: ports, indices, ranges and reset tables.
// Assumes a 10-bit AT I/O address and byte-wide configuration registers.
package ifc_pkg;
    // Index and data port locations for each level of the base strap.
    localparam logic [9:0] IDX_PORT_LO = 10'h398;
    localparam logic [9:0] DATA_PORT_LO = 10'h399;
    localparam logic [9:0] IDX_PORT_HI = 10'h26e;
    localparam logic [9:0] DATA_PORT_HI = 10'h26f;
    // Configuration register indices.
    localparam logic [7:0] IDX_FEN = 8'h00;
    localparam logic [7:0] IDX_FAR = 8'h01;
    localparam logic [7:0] IDX_PTR = 8'h02;
    // Function enable bit positions.
    localparam int FEN_PAR = 0;
    localparam int FEN_UART1 = 1;
    localparam int FEN_UART2 = 2;
    localparam int FEN_FDC = 3;
    localparam int FEN_ENC = 4;
    localparam int FEN_FDC_SEC = 5;
    localparam int FEN_IDE = 6;
    localparam int FEN_IDE_SEC = 7;
    // Power and test bit positions.
    localparam int PTR_LPT_IRQ7 = 3;
    localparam int PTR_LOCK = 6;
    // Floppy, IDE and parallel port ranges.
    localparam logic [9:0] FDC_PRI_LO = 10'h3f0;
    localparam logic [9:0] FDC_SEC_LO = 10'h370;
    localparam logic [9:0] FDC_DOR_PRI = 10'h3f2;
    localparam logic [9:0] FDC_DOR_SEC = 10'h372;
    localparam logic [9:0] IDE_PRI_LO = 10'h1f0;
    localparam logic [9:0] IDE_SEC_LO = 10'h170;
    localparam logic [9:0] IDE_PRI_ALT = 10'h3f6;
    localparam logic [9:0] IDE_SEC_ALT = 10'h376;
    localparam logic [9:0] SPAN8 = 10'h007;
    localparam logic [9:0] SPAN2 = 10'h001;
    localparam logic [9:0] PAR_A_LO = 10'h378;
    localparam logic [9:0] PAR_B_LO = 10'h3bc;
    localparam logic [9:0] PAR_B_HI = 10'h3be;
    localparam logic [9:0] PAR_C_LO = 10'h278;
    localparam logic [1:0] PAR_CODE_A = 2'h0;
    localparam logic [1:0] PAR_CODE_B = 2'h1;
    localparam logic [1:0] PAR_CODE_C = 2'h2;
    // Serial port slot bases.
    localparam logic [9:0] COM1_LO = 10'h3f8;
    localparam logic [9:0] COM2_LO = 10'h2f8;
    localparam logic [9:0] COM3_LO [4] = '{10'h3e8, 10'h338, 10'h2e8, 10'h220};
    localparam logic [9:0] COM4_LO [4] = '{10'h2e8, 10'h238, 10'h2e0, 10'h228};
    // Reset values selected by the five default straps.
    localparam logic [7:0] FEN_DEF [32] = '{
        8'h4f, 8'h4f, 8'hcf, 8'h4f, 8'h4f, 8'hcf, 8'h4b, 8'h4b,
        8'hcb, 8'h4b, 8'h4b, 8'hcb, 8'h0f, 8'h0f, 8'h0f, 8'h0f,
        8'h49, 8'h49, 8'hc9, 8'hc9, 8'h07, 8'h07, 8'h07, 8'h07,
        8'h47, 8'h47, 8'hc7, 8'h47, 8'h47, 8'hc7, 8'h08, 8'h00};
    localparam logic [7:0] FAR_DEF [32] = '{
        8'h10, 8'h11, 8'h11, 8'h39, 8'h24, 8'h38, 8'h00, 8'h01,
        8'h01, 8'h09, 8'h08, 8'h08, 8'h10, 8'h11, 8'h39, 8'h24,
        8'h00, 8'h01, 8'h01, 8'h00, 8'h10, 8'h11, 8'h39, 8'h24,
        8'h10, 8'h11, 8'h11, 8'h39, 8'h24, 8'h38, 8'h10, 8'h10};
    localparam logic [7:0] PTR_DEF = 8'h00;
    localparam logic [7:0] PTR_DEF_NONE = 8'h02;
    localparam logic [4:0] STRAP_NONE = 5'h1f;
    // Data port write phase.
    typedef enum logic {WP_IDLE = 1'b0, WP_ARMED = 1'b1} ifc_wphase_e;
endpackage : ifc_pkg

// file: hw/ifc_range_match.sv
// Inclusive I/O address range comparator.
// Assumes the caller qualifies the enable with address-enable and, except for the drive latch strobe, function enable.
`timescale 1ns/10ps
`default_nettype none
module ifc_range_match (
    input wire logic [9:0] addr_i,
    input wire logic [9:0] lo_i,
    input wire logic [9:0] hi_i,
    input wire logic en_i,
    output logic hit_o
);
    // Purely combinational so the caller registers the result once.
    assign hit_o = en_i && (addr_i >= lo_i) && (addr_i <= hi_i);
endmodule : ifc_range_match
`default_nettype wire

// file: verif/ifc_drive_decoder_model.sv
// External decoder model for the encoded four-drive pin scheme.
// Assumes settled select and motor pin levels; meaningless in direct mode.
`timescale 1ns/10ps
`default_nettype none
module ifc_drive_decoder_model (
    input wire logic sel_zero_i,
    input wire logic sel_one_i,
    input wire logic motor_i,
    output logic [3:0] drive_n_o,
    output logic [3:0] motor_n_o
);
    // Only the coded drive is enabled, so stray pin states reach no other drive.
    always_comb
    begin
        drive_n_o = 4'hf;
        motor_n_o = 4'hf;
        drive_n_o[{sel_one_i, sel_zero_i}] = 1'b0;
        motor_n_o[{sel_one_i, sel_zero_i}] = motor_i;
    end
endmodule : ifc_drive_decoder_model
`default_nettype wire

// file: verif/test_isa_function_config_decoder.sv
// Self-checking bench for the configuration decoder.
// Assumes the package and the drive decoder model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_isa_function_config_decoder;
    logic sys_clk_i = 0, srst_i = 1, config_base_strap_i = 0, aen_i = 0, iow_n_i = 1, ior_n_i = 1;
    logic uart1_irq_i = 0, uart2_irq_i = 0, par_irq_i = 0, oe_q = 0;
    logic [4:0] default_config_straps_i = 0;
    logic [9:0] isa_addr_i = 0, ip;
    logic [7:0] isa_data_i = 0, fdc_dor_i = 0, isa_data_o, s;
    logic isa_data_oe_o, fdc_cs_o, uart1_cs_o, uart2_cs_o, par_cs_o, fdc_clk_en_o, uart1_clk_en_o;
    logic uart2_clk_en_o, uart1_irq_o, uart2_irq_o, par_irq5_o, par_irq5_oe_o, par_irq7_o, par_irq7_oe_o;
    logic ide_chip_select_zero_n_o, ide_chip_select_one_n_o, ide_low_buffer_enable_n_o;
    logic ide_high_buffer_enable_n_o, ide_data_bit_seven_o, ide_data_bit_seven_oe_o;
    logic drive_select_pin_zero_o, drive_select_pin_one_o, motor_pin_zero_o, motor_pin_one_o;
    logic [3:0] drv_n, mot_n;
    logic [7:0] exp_q[$];
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    ifc_config_decoder i_dut (.*);
    ifc_drive_decoder_model i_dec (.sel_zero_i(drive_select_pin_zero_o), .sel_one_i(drive_select_pin_one_o),
        .motor_i(motor_pin_zero_o), .drive_n_o(drv_n), .motor_n_o(mot_n));
    // Clock, plus a cycle ceiling so a stuck run still reaches the verdict.
    always #25 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic pc(input logic got, input logic exp);
        chk({7'h0, got}, {7'h0, exp});
    endtask : pc
    // Read data is matched against the oldest note when output enable rises.
    always @(negedge sys_clk_i)
    begin
        if (isa_data_oe_o === 1'b1 && !oe_q)
            chk(isa_data_o, exp_q.pop_front());
        oe_q <= isa_data_oe_o === 1'b1;
    end
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        isa_addr_i = a;
        isa_data_i = d;
        iow_n_i = 0;
        @(negedge sys_clk_i);
        iow_n_i = 1;
        repeat (2) @(negedge sys_clk_i);
    endtask : wr
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        isa_addr_i = a;
        ior_n_i = 0;
        repeat (2) @(negedge sys_clk_i);
        ior_n_i = 1;
        repeat (2) @(negedge sys_clk_i);
    endtask : rd
    task automatic cfg(input logic [7:0] i, input logic [7:0] d);
        wr(ip, i);
        wr(ip + 10'h1, d);
        wr(ip + 10'h1, d);
    endtask : cfg
    task automatic at(input logic [9:0] a);
        isa_addr_i = a;
        @(negedge sys_clk_i);
    endtask : at
    task automatic close_out();
        if (exp_q.size() != 0)
            n_mismatch++;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // Two passes, one per base strap level; the second reset must also clear the lock.
    initial
    begin
        void'($urandom(81086));
        for (int b = 0; b < 2; b++)
        begin
            s = 8'($urandom);
            config_base_strap_i = b[0];
            default_config_straps_i = s[4:0];
            ip = b ? ifc_pkg::IDX_PORT_HI : ifc_pkg::IDX_PORT_LO;
            srst_i = 1;
            repeat (10) @(negedge sys_clk_i);
            srst_i = 0;
            @(negedge sys_clk_i);
            wr(ip, ifc_pkg::IDX_FEN);
            rd(ip + 10'h1, ifc_pkg::FEN_DEF[s[4:0]]);
            wr(ip, ifc_pkg::IDX_FAR);
            rd(ip, ifc_pkg::IDX_FAR);
            wr(ip + 10'h1, 8'hc3);
            rd(ip + 10'h1, ifc_pkg::FAR_DEF[s[4:0]]);
            wr(ip + 10'h1, 8'h00);
            rd(ip + 10'h1, 8'h00);
            cfg(ifc_pkg::IDX_FEN, 8'h1b);
            uart2_irq_i = 1;
            at(10'h3f8);
            pc(uart1_cs_o, 1);
            pc(uart2_cs_o, 0);
            pc(uart2_irq_o, 1);
            pc(uart2_clk_en_o, 0);
            pc(fdc_clk_en_o, 1);
            aen_i = 1;
            at(10'h3f8);
            pc(uart1_cs_o, 0);
            aen_i = 0;
            at(10'h37a);
            pc(par_cs_o, 1);
            pc(par_irq5_oe_o, 1);
            at(10'h3f0);
            pc(fdc_cs_o, 1);
            at(10'h1f0);
            pc(ide_chip_select_zero_n_o, 1);
            for (int k = 0; k < 4; k++)
            begin
                fdc_dor_i = 8'($urandom);
                @(negedge sys_clk_i);
                pc(drive_select_pin_one_o, fdc_dor_i[1]);
                pc(drive_select_pin_zero_o, fdc_dor_i[0]);
                pc(motor_pin_zero_o, ~fdc_dor_i[4 + fdc_dor_i[1:0]]);
                pc(drv_n[fdc_dor_i[1:0]], 0);
            end
            isa_addr_i = 10'h3f2;
            iow_n_i = 0;
            @(negedge sys_clk_i);
            pc(motor_pin_one_o, 1);
            iow_n_i = 1;
            @(negedge sys_clk_i);
            pc(motor_pin_one_o, 0);
            cfg(ifc_pkg::IDX_PTR, 8'h08);
            at(10'h37a);
            pc(par_irq7_oe_o, 1);
            cfg(ifc_pkg::IDX_FAR, 8'hcb);
            at(10'h37a);
            pc(par_cs_o, 0);
            pc(par_irq7_oe_o, 0);
            at(10'h224);
            pc(uart1_cs_o, 1);
            cfg(ifc_pkg::IDX_PTR, 8'h40);
            uart2_irq_i = 0;
            cfg(ifc_pkg::IDX_FEN, 8'h00);
            rd(ip + 10'h1, 8'h1b);
        end
        close_out();
    end
endmodule : test_isa_function_config_decoder
`default_nettype wire
